/* verilog/sotp_map.vh */
// constants for the secured otp lock control block
`ifndef SOTP_MAP_VH
`define SOTP_MAP_VH
`define SOTP_OP_ENTER 8'hb1
`define SOTP_OP_EXIT 8'hc1
`define SOTP_OP_RDLOCK 8'h2b
`define SOTP_OP_WRLOCK 8'h2f
`define SOTP_OP_PP 8'h02
`define SOTP_OP_SE 8'h20
`define SOTP_OP_WRSR 8'h01
`define SOTP_OP_WRSR2 8'h31
`define SOTP_OP_WREN 8'h06
`define SOTP_OP_READ 8'h03
`define SOTP_BIT_FACTORY 0
`define SOTP_BIT_CUST 1
`define SOTP_SN_LAST 24'h00000f
`define SOTP_GEN_LAST 24'h0001ff
`define SOTP_CLK_MHZ 40
`define SOTP_HOLDOFF_MS 1
`define SOTP_HOLDOFF_CYC (`SOTP_HOLDOFF_MS * 1000 * `SOTP_CLK_MHZ)
`endif

/* verilog/sotp_lock_ctrl.v */
// secured otp lock control: serial command decoder and lock status
// Overview of operation
// [RULE1] exit opcode leaves otp mode
// [RULE2] exit accepted in one-line and four-line modes
// [RULE3] 2bh returns lock status, repeats, always
// [RULE4] bit 0 shows factory lock
// [RULE5] lock write can only set bit 1
// [RULE6] after lockdown bit1 and otp frozen
// [RULE7] otp mode blocks main array writes
// [RULE8] lock write needs no write enable
// [RULE9] cs off byte boundary discards lock write
// [RULE10] host programs via enter, program, exit
// [RULE11] otp map: serial field, general area
// [RULE12] writes ignored during power-up holdoff
// [RULE13] b1h enters otp mode, reads/programs go there
// [RULE14] otp mode rejects status and lock writes
`timescale 1ns/1ps
`include "sotp_map.vh"
module sotp_lock_ctrl #(
  parameter HOLDOFF_CYC = `SOTP_HOLDOFF_CYC
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_cs_b,
  input wire i_sclk,
  input wire [3:0] i_io,
  input wire i_four_line,
  input wire i_factory_lock,
  output reg [3:0] o_io,
  output reg [3:0] o_io_oe,
  output reg o_otp_mode,
  output reg o_customer_lockdown_bit,
  output reg o_write_ready,
  output reg o_main_wr_pulse,
  output reg o_otp_wr_pulse,
  output reg o_sn_field_sel,
  output reg [23:0] o_addr,
  output reg o_status_wr_pulse
);
  localparam ST_OP = 4'h1;
  localparam ST_ADDR = 4'h2;
  localparam ST_OUT = 4'h4;
  localparam ST_DATA = 4'h8;

  // pin synchronisers: [0] first flop, [1] second, [2] edge history
  reg [2:0] cs_s;
  reg [2:0] ck_s;
  reg [3:0] io_m;
  reg [3:0] io_s;
  reg [1:0] fl_s;
  reg [1:0] fk_s;
  // frame decode
  reg [3:0] state;
  reg [7:0] shreg;
  reg [7:0] opcode;
  reg op_done;
  reg [4:0] bitcnt;
  reg [1:0] byte_cnt;
  reg [23:0] addr;
  // read-out
  reg [7:0] tx;
  reg [2:0] out_cnt;
  // command state
  reg wel;
  reg fact;
  reg [1:0] strap_wait;
  reg [31:0] hold_cnt;

  function is_write;
    input [7:0] op;
    begin
      is_write = (op == `SOTP_OP_PP) || (op == `SOTP_OP_SE);
    end
  endfunction

  // state that follows an opcode byte
  function [3:0] after_opcode;
    input [7:0] op;
    begin
      if (op == `SOTP_OP_RDLOCK) begin
        after_opcode = ST_OUT;
      end else if (is_write(op) || (op == `SOTP_OP_READ)) begin
        after_opcode = ST_ADDR;
      end else if ((op == `SOTP_OP_WRLOCK) || (op == `SOTP_OP_WRSR) ||
          (op == `SOTP_OP_WRSR2)) begin
        after_opcode = ST_DATA;
      end else begin
        after_opcode = ST_OP;
      end
    end
  endfunction

  wire four_line = fl_s[1];
  // frame_on drops in the same cycle that cs_end rises, so cs_end sees the last state
  wire frame_on = ~cs_s[1] & ~cs_s[2];
  wire cs_end = cs_s[1] & ~cs_s[2];
  wire ck_rise = ck_s[1] & ~ck_s[2];
  wire ck_fall = ~ck_s[1] & ck_s[2];
  wire [7:0] lock_val = {6'h00, o_customer_lockdown_bit, fact}; // [RULE4]
  wire [4:0] step = four_line ? 5'd4 : 5'd1;
  wire [7:0] nsh = four_line ? {shreg[3:0], io_s} : {shreg[6:0], io_s[0]};
  wire [4:0] nbit = bitcnt + step;
  wire shift_en = frame_on & ck_rise & (state != ST_OUT);
  wire byte_in = shift_en & (nbit == 5'd8);
  wire cmd_frame = (state == ST_OP) && op_done && (bitcnt == 5'h00);
  wire lock_frame = (opcode == `SOTP_OP_WRLOCK) && (state == ST_DATA) &&
    (byte_cnt == 2'h1) && (bitcnt == 5'h00); // [RULE9]
  wire sr_frame = (state == ST_DATA) &&
    ((opcode == `SOTP_OP_WRSR) || (opcode == `SOTP_OP_WRSR2));
  wire wr_frame = (state == ST_DATA) && is_write(opcode);

  // host pins: two flops before any logic looks at them
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      io_m <= 4'h0;
      io_s <= 4'h0;
      fl_s <= 2'h0;
    end else begin
      cs_s <= {cs_s[1:0], i_cs_b};
      ck_s <= {ck_s[1:0], i_sclk};
      io_m <= i_io;
      io_s <= io_m;
      fl_s <= {fl_s[0], i_four_line};
    end
  end

  // strap taken once the synchroniser has settled after reset
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fk_s <= 2'h0;
      strap_wait <= 2'h0;
      fact <= 1'b0;
    end else begin
      fk_s <= {fk_s[0], i_factory_lock};
      if (strap_wait != 2'h3) begin
        strap_wait <= strap_wait + 2'h1;
        if (strap_wait == 2'h2) begin
          fact <= fk_s[1]; // [RULE4]
        end
      end
    end
  end

  // holdoff uses the shortest allowed delay; longer is the host's margin
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_cnt <= 32'h00000000;
      o_write_ready <= 1'b0;
    end else if (!o_write_ready) begin
      hold_cnt <= hold_cnt + 32'h00000001;
      if (hold_cnt >= HOLDOFF_CYC - 1) begin
        o_write_ready <= 1'b1; // [RULE12]
      end
    end
  end

  // bit shifter: one or four bits per rising sclk
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shreg <= 8'h00;
      bitcnt <= 5'h00;
    end else if (!frame_on) begin
      bitcnt <= 5'h00;
    end else if (shift_en) begin
      shreg <= nsh;
      if (nbit == 5'd8) begin
        bitcnt <= 5'h00;
      end else begin
        bitcnt <= nbit;
      end
    end
  end

  // frame walk: opcode, then address bytes, then data bytes
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_OP;
      opcode <= 8'h00;
      op_done <= 1'b0;
      byte_cnt <= 2'h0;
      addr <= 24'h000000;
    end else if (!frame_on) begin
      state <= ST_OP;
      op_done <= 1'b0;
      byte_cnt <= 2'h0;
    end else if (byte_in) begin
      case (state)
        ST_OP: begin
          opcode <= nsh;
          op_done <= 1'b1;
          addr <= 24'h000000;
          byte_cnt <= 2'h0;
          state <= after_opcode(nsh); // [RULE3] [RULE13]
        end
        ST_ADDR: begin
          addr <= {addr[15:0], nsh};
          if (byte_cnt == 2'h2) begin
            byte_cnt <= 2'h0;
            state <= ST_DATA;
          end else begin
            byte_cnt <= byte_cnt + 2'h1;
          end
        end
        ST_DATA: begin
          // saturates: three or more data bytes look alike
          if (byte_cnt != 2'h3) begin
            byte_cnt <= byte_cnt + 2'h1;
          end
        end
        default: begin
          state <= ST_OP;
        end
      endcase
    end
  end

  // lock status repeats for as long as clocks run [RULE3]
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx <= 8'h00;
      out_cnt <= 3'h0;
      o_io <= 4'h0;
      o_io_oe <= 4'h0;
    end else if (!frame_on) begin
      o_io_oe <= 4'h0;
      out_cnt <= 3'h0;
    end else if (byte_in && (state == ST_OP) &&
        (nsh == `SOTP_OP_RDLOCK)) begin
      tx <= lock_val;
      out_cnt <= 3'h0;
    end else if (ck_fall && (state == ST_OUT)) begin
      if (four_line) begin
        o_io <= tx[7:4];
        o_io_oe <= 4'hf; // [RULE2]
        if (out_cnt[2]) begin
          tx <= lock_val;
          out_cnt <= 3'h0;
        end else begin
          tx <= {tx[3:0], 4'h0};
          out_cnt <= 3'h4;
        end
      end else begin
        o_io <= {2'b00, tx[7], 1'b0};
        o_io_oe <= 4'h2;
        if (out_cnt == 3'h7) begin
          tx <= lock_val;
        end else begin
          tx <= {tx[6:0], 1'b0};
        end
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  // commands act when the frame closes; refused writes still clear wel, and refused otp writes still update o_addr
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wel <= 1'b0;
      o_otp_mode <= 1'b0;
      o_customer_lockdown_bit <= 1'b0;
      o_main_wr_pulse <= 1'b0;
      o_otp_wr_pulse <= 1'b0;
      o_status_wr_pulse <= 1'b0;
      o_sn_field_sel <= 1'b0;
      o_addr <= 24'h000000;
    end else begin
      o_main_wr_pulse <= 1'b0;
      o_otp_wr_pulse <= 1'b0;
      o_status_wr_pulse <= 1'b0;
      if (cs_end && cmd_frame) begin
        case (opcode)
          `SOTP_OP_WREN: begin
            wel <= o_write_ready; // [RULE12]
          end
          `SOTP_OP_ENTER: begin
            o_otp_mode <= 1'b1; // [RULE13]
          end
          `SOTP_OP_EXIT: begin
            o_otp_mode <= 1'b0; // [RULE1] [RULE2]
          end
          default: begin
          end
        endcase
      end
      // lock write takes no write enable [RULE8]
      if (cs_end && lock_frame && o_write_ready && !o_otp_mode &&
          !o_customer_lockdown_bit) begin // [RULE14] [RULE6]
        o_customer_lockdown_bit <= shreg[`SOTP_BIT_CUST]; // [RULE5]
      end
      if (cs_end && sr_frame) begin
        if (wel && o_write_ready) begin
          o_status_wr_pulse <= !o_otp_mode; // [RULE14]
        end
        wel <= 1'b0;
      end
      if (cs_end && wr_frame) begin
        if (wel && o_write_ready) begin // [RULE12]
          o_addr <= addr;
          o_sn_field_sel <= (addr <= `SOTP_SN_LAST); // [RULE11]
          if (o_otp_mode) begin
            o_otp_wr_pulse <= !o_customer_lockdown_bit &&
              (addr <= `SOTP_GEN_LAST); // [RULE6] [RULE11]
          end else begin
            o_main_wr_pulse <= 1'b1; // [RULE7]
          end
        end
        wel <= 1'b0;
      end
    end
  end
endmodule // sotp_lock_ctrl

/* tb/sotp_lock_ctrl_monitor.sv */
// checker on the otp lock control ports
`timescale 1ns/1ps
module sotp_lock_ctrl_monitor (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_cs_b,
  input wire o_otp_mode,
  input wire o_customer_lockdown_bit,
  input wire o_write_ready,
  input wire o_main_wr_pulse,
  input wire o_otp_wr_pulse,
  input wire o_sn_field_sel,
  input wire [23:0] o_addr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // state may move only once the frame has closed
  sequence s_cs_up; i_cs_b && $past(i_cs_b, 2); endsequence
  property p_mode; $changed(o_otp_mode) |-> s_cs_up; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_main; o_main_wr_pulse |-> !o_otp_mode; endproperty
  a_main: assert property (p_main) else $error("main");
  property p_otp; o_otp_wr_pulse |-> !o_customer_lockdown_bit; endproperty
  a_otp: assert property (p_otp) else $error("otp");
  property p_map; o_otp_wr_pulse |=> o_addr <= 24'h0001ff
    && o_sn_field_sel == (o_addr <= 24'h00000f); endproperty
  a_map: assert property (p_map) else $error("map");
  property p_keep;
    o_customer_lockdown_bit |=> o_customer_lockdown_bit; endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_lock;
    $rose(o_customer_lockdown_bit) |-> (!o_otp_mode) and s_cs_up;
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_hold;
    (o_main_wr_pulse || o_otp_wr_pulse) |-> o_write_ready; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_in; o_otp_wr_pulse |-> o_otp_mode; endproperty
  a_in: assert property (p_in) else $error("in");
endmodule // sotp_lock_ctrl_monitor
bind sotp_lock_ctrl sotp_lock_ctrl_monitor mon_u (.*);

/* tb/sotp_host.sv */
// host model: sends frames, msb first, and clocks read data back
`timescale 1ns/1ps
module sotp_host (
  input wire i_ref_clk,
  input wire i_four_line,
  input wire [3:0] i_dev_io,
  output reg o_cs_b,
  output reg o_sclk,
  output reg [3:0] o_io
);
  reg [7:0] rd;
  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
    rd = 8'h00;
  end
  // nb bits sent, nx more bits read; sampled late in high phase
  task frame(input integer nb, input integer nx, input [47:0] d);
    reg [47:0] s;
    integer k;
    begin
      s = d << (48 - nb);
      @(posedge i_ref_clk);
      #1 o_cs_b = 1'b0;
      for (k = 0; k < nb + nx; k = k + (i_four_line ? 4 : 1)) begin
        o_io = i_four_line ? s[47:44] : {3'h0, s[47]};
        s = i_four_line ? s << 4 : s << 1;
        #100 o_sclk = 1'b1;
        #99 rd = i_four_line ? {rd[3:0], i_dev_io} : {rd[6:0], i_dev_io[1]};
        #1 o_sclk = 1'b0;
      end
      #100 o_cs_b = 1'b1;
      o_io = ~o_io;
      #300;
    end
  endtask
endmodule // sotp_host

/* tb/sotp_lock_ctrl_bench.sv */
// bench for the otp lock control, frames sent through the host model
`timescale 1ns/1ps
module sotp_lock_ctrl_bench;
  reg i_ref_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg i_four_line = 1'b0;
  reg i_factory_lock = 1'b1;
  wire i_cs_b, i_sclk, o_otp_mode, o_customer_lockdown_bit, o_write_ready;
  wire o_main_wr_pulse, o_otp_wr_pulse, o_sn_field_sel, o_status_wr_pulse;
  wire [3:0] o_io, o_io_oe, h_io;
  wire [3:0] i_io = (o_io_oe & o_io) | (~o_io_oe & h_io);
  wire [23:0] o_addr;
  integer fails = 0, samples_checked = 0, pm = 0, po = 0, ps = 0, k;
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    pm = pm + o_main_wr_pulse;
    po = po + o_otp_wr_pulse;
    ps = ps + o_status_wr_pulse;
  end
  sotp_lock_ctrl #(.HOLDOFF_CYC(2000)) dut_u (.i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_sclk(i_sclk), .i_io(i_io),
    .i_four_line(i_four_line), .i_factory_lock(i_factory_lock),
    .o_io(o_io), .o_io_oe(o_io_oe), .o_otp_mode(o_otp_mode),
    .o_customer_lockdown_bit(o_customer_lockdown_bit),
    .o_write_ready(o_write_ready), .o_main_wr_pulse(o_main_wr_pulse),
    .o_otp_wr_pulse(o_otp_wr_pulse), .o_sn_field_sel(o_sn_field_sel),
    .o_addr(o_addr), .o_status_wr_pulse(o_status_wr_pulse));
  sotp_host host_u (.i_ref_clk(i_ref_clk), .i_four_line(i_four_line),
    .i_dev_io(i_io), .o_cs_b(i_cs_b), .o_sclk(i_sclk), .o_io(h_io));
  task give_verdict;
    begin
      if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] n, input [23:0] e, input [23:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task f(input integer nb, input [47:0] d);
    host_u.frame(nb, 0, d);
  endtask
  task w(input [23:0] a);
    begin
      f(8, 8'h06);
      f(40, {8'h02, a, 8'h5a});
    end
  endtask
  initial begin
    repeat (10) @(posedge i_ref_clk);
    #1 i_rst_b = 1'b1;
    w(24'h000100);
    chk("hold", 0, pm);
    for (k = 0; k < 3000 && o_write_ready !== 1'b1; k = k + 1)
      @(posedge i_ref_clk);
    chk("rdy", 1, o_write_ready);
    if (o_write_ready === 1'b1) begin
      host_u.frame(8, 24, 8'h2b);
      chk("rd", 8'h01, host_u.rd);
      w(24'h000100);
      f(12, 12'h2ff);
      chk("lk", 0, o_customer_lockdown_bit);
      f(8, 8'hb1);
      chk("om", 1, o_otp_mode);
      w(24'h00000f);
      chk("sn", 1, o_sn_field_sel);
      w(24'h000010);
      chk("sn", 0, o_sn_field_sel);
      chk("ad", 24'h000010, o_addr);
      w(24'h000200);
      f(16, 16'h2fff);
      f(8, 8'h06);
      f(16, 16'h0100);
      chk("ct", 24'h0201, {po[7:0], pm[7:0]});
      chk("lk", 0, o_customer_lockdown_bit);
      chk("sr", 0, ps);
      @(posedge i_ref_clk);
      #1 i_four_line = 1'b1;
      f(8, 8'hc1);
      chk("om", 0, o_otp_mode);
      host_u.frame(8, 8, 8'h2b);
      chk("rd", 8'h01, host_u.rd);
      @(posedge i_ref_clk);
      #1 i_four_line = 1'b0;
      f(8, 8'h06);
      f(16, 16'h0100);
      chk("sr", 1, ps);
      f(16, 16'h2fff);
      host_u.frame(8, 8, 8'h2b);
      chk("rd", 8'h03, host_u.rd);
      f(16, 16'h2f00);
      f(8, 8'hb1);
      w(24'h000020);
      chk("ct", 24'h0201, {po[7:0], pm[7:0]});
      chk("lk", 1, o_customer_lockdown_bit);
      @(posedge i_ref_clk);
      #1 i_rst_b = 1'b0;
      i_factory_lock = 1'b0;
      repeat (10) @(posedge i_ref_clk);
      #1 i_rst_b = 1'b1;
      host_u.frame(8, 8, 8'h2b);
      chk("rd", 8'h00, host_u.rd);
    end
    give_verdict;
  end
endmodule // sotp_lock_ctrl_bench
